// ---- logic/gpfi_top.sv ----
// Parallel I/O controller core: ownership, direction, output values,
// glitch filters, pin readback and change interrupts for 32 lines.
// Assumes pins arrive asynchronously; peripheral signals share mclk.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gpfi_top #(
    parameter logic [31:0] OWN_RESET = gpfi_pkg::RST_OWN
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    // Register port
    input  wire logic [gpfi_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [gpfi_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [gpfi_pkg::DATA_W-1:0] reg_rdata,
    // Pins
    input  wire logic [31:0]                 pin_in,
    output logic      [31:0]                 pin_out,
    output logic      [31:0]                 pin_oen_n,
    // Peripheral side
    input  wire logic [31:0]                 periph_out,
    input  wire logic [31:0]                 periph_oe,
    output logic      [31:0]                 periph_in,
    // Interrupt
    output logic                             irq
);
    import gpfi_pkg::*;

    // Register map, byte offsets on the register port
    //   0x00 write ones: controller takes those pins
    //   0x04 write ones: peripherals take those pins
    //   0x08 read: pins owned by the controller
    //   0x10 write ones: pins become outputs
    //   0x14 write ones: pins become inputs
    //   0x18 read: pins set as outputs
    //   0x20 write ones: glitch filter selected
    //   0x24 write ones: glitch filter deselected
    //   0x28 read: pins with the filter selected
    //   0x30 write ones: stored output value set
    //   0x34 write ones: stored output value cleared
    //   0x38 read: stored output values
    //   0x3c read: pin levels as seen by the logic
    //   0x40 write ones: change interrupt enabled
    //   0x44 write ones: change interrupt disabled
    //   0x48 read: interrupt mask
    //   0x4c read: change status, cleared by the read
    // Unmapped offsets ignore writes and read as zero.

    // Timing seen from the pins and the register port:
    // a pin edge reaches the change status three cycles later without
    // the filter and four with it; the interrupt rises together
    // with the status bit. Writes show on the pin drivers at the write edge
    // itself, and read data stands for one cycle only.
    // The filter costs one sample of delay in return for dropping
    // single-cycle pulses.

    // Hazards kept in mind:
    // the first synchroniser stage feeds only the second one;
    // no edge is reported in the first cycle after reset, since the
    // previous level is not known yet;
    // an edge in the cycle of a status read survives into the next read.

    // Registered state of the whole block
    gpfi_state_type st;

    // Value the state takes at the next rising edge
    gpfi_state_type next_st;

    // Next-state logic: input path, registers, pin drivers, interrupt
    always_comb begin
        // Write strobe views
        logic [31:0] wr_m;        // Write data used as a per-pin mask
        logic        hit_own_set; // Ownership take write
        logic        hit_own_clr; // Ownership release write
        logic        hit_dir_set; // Direction output write
        logic        hit_dir_clr; // Direction input write
        logic        hit_flt_set; // Filter select write
        logic        hit_flt_clr; // Filter deselect write
        logic        hit_val_set; // Output value set write
        logic        hit_val_clr; // Output value clear write
        logic        hit_irq_set; // Interrupt enable write
        logic        hit_irq_clr; // Interrupt disable write
        // Read strobe views
        logic        rd_own;      // Ownership status read
        logic        rd_dir;      // Direction status read
        logic        rd_flt;      // Filter status read
        logic        rd_val;      // Output value status read
        logic        rd_pin;      // Pin level status read
        logic        rd_msk;      // Interrupt mask read
        logic        rd_chg;      // Change status read
        // Input path views
        logic [31:0] raw_lvl;     // Pin level after two flip-flops
        logic [31:0] agree;       // Pins whose last two samples match
        logic [31:0] seen;        // Level after the optional filter
        logic [31:0] rise;        // Pins that went from low to high
        logic [31:0] fall;        // Pins that went from high to low
        logic [31:0] edges;       // Pins whose level moved
        logic [31:0] pend;        // Unmasked change bits
        // Driver views
        logic [31:0] ctl_drive;   // Pins the controller drives
        logic [31:0] per_drive;   // Pins a peripheral drives
        logic [31:0] drive_en;    // Pins driven by anyone
        logic [31:0] drive_val;   // Level put on each driven pin

        // Defaults: nothing decoded, state held
        wr_m        = reg_wdata;
        hit_own_set = 1'b0;
        hit_own_clr = 1'b0;
        hit_dir_set = 1'b0;
        hit_dir_clr = 1'b0;
        hit_flt_set = 1'b0;
        hit_flt_clr = 1'b0;
        hit_val_set = 1'b0;
        hit_val_clr = 1'b0;
        hit_irq_set = 1'b0;
        hit_irq_clr = 1'b0;
        rd_own      = 1'b0;
        rd_dir      = 1'b0;
        rd_flt      = 1'b0;
        rd_val      = 1'b0;
        rd_pin      = 1'b0;
        rd_msk      = 1'b0;
        rd_chg      = 1'b0;
        raw_lvl     = RST_ZERO;
        agree       = RST_ZERO;
        seen        = RST_ZERO;
        rise        = RST_ZERO;
        fall        = RST_ZERO;
        edges       = RST_ZERO;
        pend        = RST_ZERO;
        ctl_drive   = RST_ZERO;
        per_drive   = RST_ZERO;
        drive_en    = RST_ZERO;
        drive_val   = RST_ZERO;
        next_st     = st;

        // Write strobe decode; a status offset written is ignored
        if (reg_wr) begin
            case (reg_addr)
                OFS_OWN_SET: begin
                    hit_own_set = 1'b1;
                end
                OFS_OWN_CLR: begin
                    hit_own_clr = 1'b1;
                end
                OFS_DIR_SET: begin
                    hit_dir_set = 1'b1;
                end
                OFS_DIR_CLR: begin
                    hit_dir_clr = 1'b1;
                end
                OFS_FLT_SET: begin
                    hit_flt_set = 1'b1;
                end
                OFS_FLT_CLR: begin
                    hit_flt_clr = 1'b1;
                end
                OFS_VAL_SET: begin
                    hit_val_set = 1'b1;
                end
                OFS_VAL_CLR: begin
                    hit_val_clr = 1'b1;
                end
                OFS_IRQ_SET: begin
                    hit_irq_set = 1'b1;
                end
                OFS_IRQ_CLR: begin
                    hit_irq_clr = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Read strobe decode; unmapped offsets read as zero
        if (reg_rd) begin
            case (reg_addr)
                OFS_OWN_STAT: begin
                    rd_own = 1'b1;
                end
                OFS_DIR_STAT: begin
                    rd_dir = 1'b1;
                end
                OFS_FLT_STAT: begin
                    rd_flt = 1'b1;
                end
                OFS_VAL_STAT: begin
                    rd_val = 1'b1;
                end
                OFS_PIN_STAT: begin
                    rd_pin = 1'b1;
                end
                OFS_IRQ_MASK: begin
                    rd_msk = 1'b1;
                end
                OFS_CHG_STAT: begin
                    rd_chg = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Two-stage pin synchroniser, then a third stage for the filter
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        raw_lvl       = st.sync2;

        // Filter: a level passes only once two samples agree,
        // so a pulse one clock long never reaches the filtered level
        agree = ~(st.sync2 ^ st.sync3);
        for (int i = 0; i < DATA_W; i++) begin
            if (agree[i]) begin
                next_st.filt[i] = raw_lvl[i];
            end
        end

        // Input seen by controller and peripheral alike
        for (int i = 0; i < DATA_W; i++) begin
            if (st.flt_sel[i]) begin
                seen[i] = next_st.filt[i];
            end else begin
                seen[i] = raw_lvl[i];
            end
        end

        // Edge detection on every pin, whatever its owner, direction or mask;
        // the first cycle after reset has no history and reports nothing
        next_st.seen_prev = seen;
        next_st.seen_ok   = 1'b1;
        if (st.seen_ok) begin
            rise = seen & ~st.seen_prev;
            fall = ~seen & st.seen_prev;
        end
        edges = rise | fall;

        // Ownership: controller or peripheral per pin
        for (int i = 0; i < DATA_W; i++) begin
            if (hit_own_set && wr_m[i]) begin
                next_st.own[i] = 1'b1;
            end
            if (hit_own_clr && wr_m[i]) begin
                next_st.own[i] = 1'b0;
            end
        end

        // Direction is stored even on pins a peripheral drives
        for (int i = 0; i < DATA_W; i++) begin
            if (hit_dir_set && wr_m[i]) begin
                next_st.dir[i] = 1'b1;
            end
            if (hit_dir_clr && wr_m[i]) begin
                next_st.dir[i] = 1'b0;
            end
        end

        // Filter selection, independent of ownership
        for (int i = 0; i < DATA_W; i++) begin
            if (hit_flt_set && wr_m[i]) begin
                next_st.flt_sel[i] = 1'b1;
            end
            if (hit_flt_clr && wr_m[i]) begin
                next_st.flt_sel[i] = 1'b0;
            end
        end

        // Stored output values; zero bits of the mask change nothing
        for (int i = 0; i < DATA_W; i++) begin
            if (hit_val_set && wr_m[i]) begin
                next_st.out_val[i] = 1'b1;
            end
            if (hit_val_clr && wr_m[i]) begin
                next_st.out_val[i] = 1'b0;
            end
        end

        // Interrupt mask; enables apply whoever owns the pin
        for (int i = 0; i < DATA_W; i++) begin
            if (hit_irq_set && wr_m[i]) begin
                next_st.mask[i] = 1'b1;
            end
            if (hit_irq_clr && wr_m[i]) begin
                next_st.mask[i] = 1'b0;
            end
        end

        // Change status: read clears, a new edge in the same cycle wins
        if (rd_chg) begin
            next_st.chg = edges;
        end else begin
            next_st.chg = st.chg | edges;
        end

        // Read data, valid in the cycle after the strobe only
        next_st.rdata = ({DATA_W{rd_own}} & st.own)
                      | ({DATA_W{rd_dir}} & st.dir)
                      | ({DATA_W{rd_flt}} & st.flt_sel)
                      | ({DATA_W{rd_val}} & st.out_val)
                      | ({DATA_W{rd_pin}} & seen)
                      | ({DATA_W{rd_msk}} & st.mask)
                      | ({DATA_W{rd_chg}} & (st.chg | edges));

        // Driver split: controller where owned, peripheral elsewhere
        ctl_drive = next_st.own & next_st.dir;
        per_drive = ~next_st.own & periph_oe;
        drive_en  = ctl_drive | per_drive;
        for (int i = 0; i < DATA_W; i++) begin
            if (next_st.own[i]) begin
                drive_val[i] = next_st.out_val[i];
            end else begin
                drive_val[i] = periph_out[i];
            end
        end

        // Pin outputs; the enable is low while the pin is driven
        next_st.pin_out = drive_val;
        next_st.pin_oen = ~drive_en;

        // Peripheral input is held low on controller-owned pins
        next_st.periph_in = ~next_st.own & seen;

        // Level interrupt while any unmasked change bit is set
        pend        = next_st.chg & next_st.mask;
        next_st.irq = |pend;
    end

    // State register, synchronous active-low reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st.sync1     <= RST_ZERO;
            st.sync2     <= RST_ZERO;
            st.sync3     <= RST_ZERO;
            st.filt      <= RST_ZERO;
            st.seen_prev <= RST_ZERO;
            st.seen_ok   <= 1'b0;
            st.own       <= OWN_RESET;
            st.dir       <= RST_ZERO;
            st.flt_sel   <= RST_ZERO;
            st.out_val   <= RST_ZERO;
            st.mask      <= RST_ZERO;
            st.chg       <= RST_ZERO;
            st.rdata     <= RST_ZERO;
            st.pin_out   <= RST_ZERO;
            st.pin_oen   <= RST_PIN_OEN;
            st.periph_in <= RST_ZERO;
            st.irq       <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = st.rdata;
    assign pin_out   = st.pin_out;
    assign pin_oen_n = st.pin_oen;
    assign periph_in = st.periph_in;
    assign irq       = st.irq;

endmodule
`default_nettype wire

// ---- logic/gpfi_pkg.sv ----
// Constants for the 32-line parallel I/O block: offsets, reset values, widths.
// Assumes a single 50 MHz clock and a one-cycle strobe register port.
//
// How it works
// - Direction status reads one per output pin
// - Filter enable write sets selected filter bits
// - Filter disable write clears selected filter bits
// - Filter status shows selection, resets to zero
// - Set write raises stored output values
// - Clear write lowers stored output values
// - Output value status reads stored values
// - Pin level status follows the pins
// - Interrupt enable write sets mask bits
// - Interrupt enables work whatever the pin owner
// - Disable clears mask; detection keeps running
// - Change status sets on edges, clears on read
// - Mask register reflects enables, resets zero
// - Direction enable and disable stored always
// - Peripheral input held low when controller-owned
package gpfi_pkg;
    localparam int          DATA_W         = 32;
    localparam int          ADDR_W         = 8;
    localparam int          CLK_HZ         = 50_000_000;
    // Register byte offsets
    localparam logic [7:0]  OFS_OWN_SET    = 8'h00;
    localparam logic [7:0]  OFS_OWN_CLR    = 8'h04;
    localparam logic [7:0]  OFS_OWN_STAT   = 8'h08;
    localparam logic [7:0]  OFS_DIR_SET    = 8'h10;
    localparam logic [7:0]  OFS_DIR_CLR    = 8'h14;
    localparam logic [7:0]  OFS_DIR_STAT   = 8'h18;
    localparam logic [7:0]  OFS_FLT_SET    = 8'h20;
    localparam logic [7:0]  OFS_FLT_CLR    = 8'h24;
    localparam logic [7:0]  OFS_FLT_STAT   = 8'h28;
    localparam logic [7:0]  OFS_VAL_SET    = 8'h30;
    localparam logic [7:0]  OFS_VAL_CLR    = 8'h34;
    localparam logic [7:0]  OFS_VAL_STAT   = 8'h38;
    localparam logic [7:0]  OFS_PIN_STAT   = 8'h3c;
    localparam logic [7:0]  OFS_IRQ_SET    = 8'h40;
    localparam logic [7:0]  OFS_IRQ_CLR    = 8'h44;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h48;
    localparam logic [7:0]  OFS_CHG_STAT   = 8'h4c;
    // Values after reset
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
    localparam logic [31:0] RST_OWN        = 32'hffff_ffff;
    localparam logic [31:0] RST_PIN_OEN    = 32'hffff_ffff;
    // All state of the block
    typedef struct packed {
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] sync3;
        logic [31:0] filt;
        logic [31:0] seen_prev;
        logic        seen_ok;
        logic [31:0] own;
        logic [31:0] dir;
        logic [31:0] flt_sel;
        logic [31:0] out_val;
        logic [31:0] mask;
        logic [31:0] chg;
        logic [31:0] rdata;
        logic [31:0] pin_out;
        logic [31:0] pin_oen;
        logic [31:0] periph_in;
        logic        irq;
    } gpfi_state_type;
endpackage

// ---- verif/gpfi_pins.sv ----
// Pad model for the I/O core.
// Assumes the outside drive yields where the core drives.
`timescale 1ns/1ps
`default_nettype none
module gpfi_pins (
    // Drives
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oen_n,
    input  wire logic [31:0] ext_drive,
    // Pads
    output logic      [31:0] pad
);
    // Core wins where its enable is low
    assign pad = (pin_out & ~pin_oen_n) | (ext_drive & pin_oen_n);
endmodule
`default_nettype wire

// ---- verif/gpfi_asserts.sv ----
// Port checker for the I/O core, bound below.
// Assumes every pin stays owned by the core.
`timescale 1ns/1ps
`default_nettype none
module gpfi_asserts (
    // Clock, reset, register port
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Pads, peripheral input, interrupt
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oen_n,
    input wire logic [31:0] periph_in,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Writes against pads, reads against writes
    chk_set_drives: assert property (reg_wr && reg_addr == 8'h30 |=>
        (~pin_oen_n & $past(reg_wdata) & ~pin_out) == 0) else $error("set miss");
    chk_clr_drives: assert property (reg_wr && reg_addr == 8'h34 |=>
        (~pin_oen_n & $past(reg_wdata) & pin_out) == 0) else $error("clear miss");
    chk_dir_reads: assert property (reg_rd && reg_addr == 8'h18 |=>
        reg_rdata == ~pin_oen_n) else $error("direction read");
    chk_mask_reads: assert property ((reg_wr && reg_addr == 8'h40) ##1 !reg_wr
        ##1 (reg_rd && reg_addr == 8'h48) |=>
        (reg_rdata & $past(reg_wdata, 3)) == $past(reg_wdata, 3)) else $error("mask read");
    chk_flt_clears: assert property ((reg_wr && reg_addr == 8'h24) ##1 !reg_wr
        ##1 (reg_rd && reg_addr == 8'h28) |=>
        (reg_rdata & $past(reg_wdata, 3)) == 0) else $error("filter read");
    chk_pin_level: assert property ($stable(pin_in) [*6] ##0 (reg_rd && reg_addr == 8'h3c)
        |=> reg_rdata == $past(pin_in)) else $error("pin level read");
    chk_irq_off: assert property ((reg_wr && reg_addr == 8'h44 && &reg_wdata)
        |-> ##2 !irq) else $error("masked interrupt");
    chk_periph_low: assert property (periph_in == 0) else $error("peripheral input");
endmodule
bind gpfi_top gpfi_asserts chk_u (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oen_n(pin_oen_n), .periph_in(periph_in), .irq(irq));
`default_nettype wire

// ---- verif/gpfi_top_tb.sv ----
// Bench for the I/O core: register sequences and pad pulses.
// Assumes the pad model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module gpfi_top_tb;
    logic        mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, ext = 32'h0, reg_rdata, pin_out, pin_oen_n, pad;
    int          num_errors = 0, n_tests = 0, cycles = 0;
    // Clock and hang guard
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end
    gpfi_top dut_u (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pad), .pin_out(pin_out),
        .pin_oen_n(pin_oen_n), .periph_out(ext), .periph_oe(32'h0), .periph_in(), .irq(irq));
    gpfi_pins pins_u (.pin_out(pin_out), .pin_oen_n(pin_oen_n), .ext_drive(ext), .pad(pad));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests = n_tests + 1;
        if (seen !== want) begin
            num_errors = num_errors + 1;
            $display("MISMATCH %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    // One-cycle write and read strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, want);
    endtask
    // One-cycle pad pulse, then settle
    task automatic pulse(input logic [31:0] m);
        @(posedge mclk);
        ext <= ext ^ m;
        @(posedge mclk);
        ext <= ext ^ m;
        repeat (8) @(posedge mclk);
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        rd(8'h18, 32'h0);
        rd(8'h28, 32'h0);
        rd(8'h38, 32'h0);
        rd(8'h48, 32'h0);
        rd(8'h0c, 32'h0);
        wr(8'h10, 32'h0000_00ff);
        wr(8'h14, 32'h0000_000f);
        rd(8'h18, 32'h0000_00f0);
        wr(8'h30, 32'h0000_00a5);
        wr(8'h34, 32'h0000_0005);
        rd(8'h38, 32'h0000_00a0);
        repeat (6) @(posedge mclk);
        rd(8'h3c, 32'h0000_00a0);
        rd(8'h4c, 32'h0000_00a0);
        check({31'h0, irq}, 32'h0);
        wr(8'h20, 32'h0000_0100);
        rd(8'h28, 32'h0000_0100);
        wr(8'h40, 32'h0000_0300);
        rd(8'h48, 32'h0000_0300);
        pulse(32'h0000_0300);
        check({31'h0, irq}, 32'h1);
        rd(8'h4c, 32'h0000_0200);
        rd(8'h4c, 32'h0);
        wr(8'h44, 32'hffff_ffff);
        rd(8'h48, 32'h0);
        pulse(32'h0000_0200);
        check({31'h0, irq}, 32'h0);
        rd(8'h4c, 32'h0000_0200);
        wr(8'h24, 32'h0000_0100);
        rd(8'h28, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
